// *** cfg_regs_checker.sv ***
// Port checker for the config register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_checker (
	input wire ref_clk,
	input wire rst_b,
	input wire [11:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire [47:0] accum_phase,
	input wire [47:0] mix_phase,
	input wire [15:0] sample_i,
	input wire [15:0] pattern_i,
	input wire [15:0] lane_i,
	input wire [15:0] sample_q,
	input wire [15:0] pattern_q,
	input wire [15:0] lane_q,
	input wire req_valid,
	input wire [15:0] req_i,
	input wire req_out_valid,
	input wire [15:0] req_out_i,
	input wire [5:0] tuning_word
);
	reg [47:0] off_q;
	reg [2:0] en_q;
	wire [11:0] rel = reg_addr - 12'h033D;
	wire [47:0] off_sh = off_q >> {rel[2:0], 3'b000};
	wire [15:0] want_i = en_q[0] ? pattern_i : sample_i;
	wire [15:0] want_q = en_q[2] ? pattern_q : sample_q;
	// Shadow of offset bytes and enables
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			off_q <= '0;
			en_q <= '0;
		end else if (reg_write) begin
			if (rel < 12'h0006)
				off_q[rel * 8 +: 8] <= reg_wdata;
			if (reg_addr == 12'h0347) begin
				en_q[0] <= reg_wdata[0];
				en_q[2] <= reg_wdata[2];
			end
			if (reg_addr == 12'h041E)
				en_q[1] <= reg_wdata[0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_tune_write: assert property (
		reg_write && reg_addr == 12'h0422 |=> ##1 tuning_word == $past(reg_wdata[5:0], 2)) else $error("tuning");
	a_tune_rsvd: assert property (
		reg_read && reg_addr == 12'h0422 |=> reg_rdata[7:6] == 2'b00) else $error("tuning top");
	a_test_rsvd: assert property (
		reg_read && reg_addr == 12'h0347 |=> reg_rdata[7:3] == 5'h00 && !reg_rdata[1]) else $error("test rsvd");
	a_half_rsvd: assert property (
		reg_read && reg_addr == 12'h041E |=> !reg_rdata[6] && reg_rdata[3:1] == 3'h0) else $error("half rsvd");
	a_offset_read: assert property (
		reg_read && rel < 12'h0006 |=> reg_rdata == $past(off_sh[7:0])) else $error("offset byte");
	a_mix_sum: assert property (
		mix_phase == $past(accum_phase) + $past(off_q)) else $error("mix phase");
	a_lane_i: assert property (
		lane_i == $past(want_i)) else $error("lane i");
	a_lane_q: assert property (
		lane_q == $past(want_q)) else $error("lane q");
	a_half_pass: assert property (
		req_valid && !en_q[1] && !reg_write |=> req_out_valid && req_out_i == $past(req_i)) else $error("bypass");
endmodule // cfg_regs_checker
`default_nettype wire

// *** downconv_requantizer_config_regs.v ***
// Register bank for downconverter 1 phase offset, test lanes and requantizer controls
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "downconv_requantizer_consts.vh"

// How it works
// - Upper five phase-offset bytes, read/write, reset zero
// - Lowest phase-offset byte sits just below, reset zero
// - Q enable swaps Q samples for pattern
// - I enable swaps I samples for pattern
// - Decimate-by-2 runs only when enabled
// - Filter bit: zero low-pass, one high-pass
// - Six-bit tuning word, upper two bits reserved
module downconv_requantizer_config_regs (
	input wire ref_clk,
	input wire rst_b,
	input wire [11:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	input wire [47:0] accum_phase,
	output reg [47:0] mix_phase,
	input wire sample_valid,
	input wire [15:0] sample_i,
	input wire [15:0] sample_q,
	input wire [15:0] pattern_i,
	input wire [15:0] pattern_q,
	output reg lane_valid,
	output reg [15:0] lane_i,
	output reg [15:0] lane_q,
	input wire req_valid,
	input wire [15:0] req_i,
	input wire [15:0] req_q,
	output wire req_out_valid,
	output wire [15:0] req_out_i,
	output wire [15:0] req_out_q,
	output reg [2:0] bandwidth_mode,
	output reg [5:0] tuning_word
);
	// ****************************************
	// Register storage
	// ****************************************
	reg test_i_q;
	reg test_i_d;
	reg test_q_q;
	reg test_q_d;
	reg half_rate_en_q;
	reg half_rate_en_d;
	reg high_pass_q;
	reg high_pass_d;
	reg [1:0] half_rate_rsvd_q;
	reg [1:0] half_rate_rsvd_d;
	reg mode_rsvd_q;
	reg mode_rsvd_d;
	reg [2:0] mode_q;
	reg [2:0] mode_d;
	reg [5:0] tuning_q;
	reg [5:0] tuning_d;
	reg [7:0] rdata_d;
	reg [47:0] mix_phase_d;
	reg [15:0] lane_i_d;
	reg [15:0] lane_q_d;
	wire [47:0] phase_offset;
	wire [5:0] phase_hit;
	wire hit_test;
	wire hit_half;
	wire hit_mode;
	wire hit_tune;
	wire [7:0] test_word;
	wire [7:0] half_word;
	wire [7:0] mode_word;
	wire [7:0] tune_word;

	// ****************************************
	// Phase offset bytes
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_phase
			reg [7:0] byte_q;
			always @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					byte_q <= `RESET_BYTE;
				end else if (phase_hit[g]) begin
					byte_q <= reg_wdata;
				end
			end
			// Each byte is independent, no shadow copy
			assign phase_offset[8*g+7:8*g] = byte_q;
		end
	endgenerate

	// ****************************************
	// Address decode
	// ****************************************
	// Exact match only; neighbouring offsets stay unmapped
	assign phase_hit[0] = reg_write && (reg_addr == `OFF_PHASE_OFFSET_BYTE0);
	assign phase_hit[1] = reg_write && (reg_addr == `OFF_PHASE_OFFSET_BYTE1);
	assign phase_hit[2] = reg_write && (reg_addr == `OFF_PHASE_OFFSET_BYTE2);
	assign phase_hit[3] = reg_write && (reg_addr == `OFF_PHASE_OFFSET_BYTE3);
	assign phase_hit[4] = reg_write && (reg_addr == `OFF_PHASE_OFFSET_BYTE4);
	assign phase_hit[5] = reg_write && (reg_addr == `OFF_PHASE_OFFSET_BYTE5);
	assign hit_test = reg_write && (reg_addr == `OFF_OUTPUT_TEST_ENABLE);
	assign hit_half = reg_write && (reg_addr == `OFF_HALF_RATE_CONTROL);
	assign hit_mode = reg_write && (reg_addr == `OFF_BANDWIDTH_MODE);
	assign hit_tune = reg_write && (reg_addr == `OFF_TUNING);

	// ****************************************
	// Control registers
	// ****************************************
	always @* begin
		test_i_d = test_i_q;
		test_q_d = test_q_q;
		half_rate_en_d = half_rate_en_q;
		high_pass_d = high_pass_q;
		half_rate_rsvd_d = half_rate_rsvd_q;
		mode_rsvd_d = mode_rsvd_q;
		mode_d = mode_q;
		tuning_d = tuning_q;
		if (hit_test) begin
			test_i_d = reg_wdata[`BIT_TEST_I_ENABLE];
			test_q_d = reg_wdata[`BIT_TEST_Q_ENABLE];
		end
		if (hit_half) begin
			half_rate_en_d = reg_wdata[`BIT_HALF_RATE_ENABLE];
			high_pass_d = reg_wdata[`BIT_HALF_RATE_HIGH_PASS];
			// Reserved pair is stored and read back only
			half_rate_rsvd_d = reg_wdata[`BIT_HALF_RATE_RSVD_HI:`BIT_HALF_RATE_RSVD_LO];
		end
		if (hit_mode) begin
			mode_rsvd_d = reg_wdata[`BIT_MODE_RSVD_TOP];
			mode_d = reg_wdata[`MODE_FIELD_HI:`MODE_FIELD_LO];
		end
		if (hit_tune) begin
			// Top two bits are read-only, dropped here
			tuning_d = reg_wdata[`TUNING_FIELD_HI:0];
		end
	end

	// ****************************************
	// Control register flops
	// ****************************************
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			test_i_q <= `RESET_BIT;
		end else begin
			test_i_q <= test_i_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			test_q_q <= `RESET_BIT;
		end else begin
			test_q_q <= test_q_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			half_rate_en_q <= `RESET_BIT;
		end else begin
			half_rate_en_q <= half_rate_en_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			high_pass_q <= `RESET_BIT;
		end else begin
			high_pass_q <= high_pass_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			half_rate_rsvd_q <= `RESET_RSVD_PAIR;
		end else begin
			half_rate_rsvd_q <= half_rate_rsvd_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_rsvd_q <= `RESET_BIT;
		end else begin
			mode_rsvd_q <= mode_rsvd_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= `RESET_MODE;
		end else begin
			mode_q <= mode_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tuning_q <= `RESET_TUNING;
		end else begin
			tuning_q <= tuning_d;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Read-only reserved bits are tied low
	assign test_word = {5'h00, test_q_q, 1'b0, test_i_q};
	assign half_word = {high_pass_q, 1'b0, half_rate_rsvd_q, 3'h0, half_rate_en_q};
	assign mode_word = {mode_rsvd_q, 3'h0, mode_q, 1'b0};
	assign tune_word = {2'b00, tuning_q};

	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
			`OFF_PHASE_OFFSET_BYTE0: rdata_d = phase_offset[7:0];
			`OFF_PHASE_OFFSET_BYTE1: rdata_d = phase_offset[15:8];
			`OFF_PHASE_OFFSET_BYTE2: rdata_d = phase_offset[23:16];
			`OFF_PHASE_OFFSET_BYTE3: rdata_d = phase_offset[31:24];
			`OFF_PHASE_OFFSET_BYTE4: rdata_d = phase_offset[39:32];
			`OFF_PHASE_OFFSET_BYTE5: rdata_d = phase_offset[47:40];
			`OFF_OUTPUT_TEST_ENABLE: rdata_d = test_word;
			`OFF_HALF_RATE_CONTROL: rdata_d = half_word;
			`OFF_BANDWIDTH_MODE: rdata_d = mode_word;
			`OFF_TUNING: rdata_d = tune_word;
			default: rdata_d = 8'h00;
		endcase
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ****************************************
	// Oscillator phase and test lanes
	// ****************************************
	always @* begin
		// Carry out of bit 47 is dropped: modulo 2^48
		mix_phase_d = accum_phase + phase_offset;
		lane_i_d = test_i_q ? pattern_i : sample_i;
		lane_q_d = test_q_q ? pattern_q : sample_q;
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mix_phase <= `RESET_PHASE;
		end else begin
			mix_phase <= mix_phase_d;
		end
	end

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lane_valid <= `RESET_BIT;
			lane_i <= `RESET_SAMPLE;
			lane_q <= `RESET_SAMPLE;
		end else begin
			lane_valid <= sample_valid;
			lane_i <= lane_i_d;
			lane_q <= lane_q_d;
		end
	end

	// ****************************************
	// Requantizer control copies
	// ****************************************
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bandwidth_mode <= `RESET_MODE;
			tuning_word <= `RESET_TUNING;
		end else begin
			bandwidth_mode <= mode_q;
			tuning_word <= tuning_q;
		end
	end

	// ****************************************
	// Requantizer half-rate stage
	// ****************************************
	half_rate_stage u_half_rate (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(half_rate_en_q),
		.high_pass(high_pass_q),
		.in_valid(req_valid),
		.in_i(req_i),
		.in_q(req_q),
		.out_valid(req_out_valid),
		.out_i(req_out_i),
		.out_q(req_out_q)
	);
endmodule // downconv_requantizer_config_regs

`default_nettype wire

// *** downconv_requantizer_consts.vh ***
// Register offsets, field positions and reset values for the downconverter and requantizer registers
`ifndef DOWNCONV_REQUANTIZER_CONSTS_VH
`define DOWNCONV_REQUANTIZER_CONSTS_VH

`define ADDR_W 12
`define OFF_PHASE_OFFSET_BYTE0 12'h033D
`define OFF_PHASE_OFFSET_BYTE1 12'h033E
`define OFF_PHASE_OFFSET_BYTE2 12'h033F
`define OFF_PHASE_OFFSET_BYTE3 12'h0340
`define OFF_PHASE_OFFSET_BYTE4 12'h0341
`define OFF_PHASE_OFFSET_BYTE5 12'h0342
`define OFF_OUTPUT_TEST_ENABLE 12'h0347
`define OFF_HALF_RATE_CONTROL 12'h041E
`define OFF_BANDWIDTH_MODE 12'h0420
`define OFF_TUNING 12'h0422

`define BIT_TEST_I_ENABLE 0
`define BIT_TEST_Q_ENABLE 2
`define BIT_HALF_RATE_ENABLE 0
`define BIT_HALF_RATE_RSVD_LO 4
`define BIT_HALF_RATE_RSVD_HI 5
`define BIT_HALF_RATE_HIGH_PASS 7
`define BIT_MODE_RSVD_TOP 7
`define MODE_FIELD_LO 1
`define MODE_FIELD_HI 3
`define TUNING_FIELD_HI 5

`define RESET_BYTE 8'h00
`define RESET_PHASE 48'h0000_0000_0000
`define RESET_MODE 3'h0
`define RESET_TUNING 6'h00
`define RESET_BIT 1'b0
`define RESET_RSVD_PAIR 2'b00
`define RESET_SAMPLE 16'h0000

`endif

// *** half_rate_stage.v ***
// Optional decimate-by-2 stage with low-pass or high-pass response
`timescale 1ns/1ps
`default_nettype none

module half_rate_stage (
	input wire ref_clk,
	input wire rst_b,
	input wire enable,
	input wire high_pass,
	input wire in_valid,
	input wire [15:0] in_i,
	input wire [15:0] in_q,
	output reg out_valid,
	output reg [15:0] out_i,
	output reg [15:0] out_q
);
	reg phase_q;
	reg [15:0] prev_i_q;
	reg [15:0] prev_q_q;
	wire [16:0] sum_i;
	wire [16:0] sum_q;

	// Two-tap half-band: sum for low-pass, difference for high-pass
	assign sum_i = high_pass ? ({in_i[15], in_i} - {prev_i_q[15], prev_i_q}) :
		({in_i[15], in_i} + {prev_i_q[15], prev_i_q});
	assign sum_q = high_pass ? ({in_q[15], in_q} - {prev_q_q[15], prev_q_q}) :
		({in_q[15], in_q} + {prev_q_q[15], prev_q_q});

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q <= 1'b0;
			prev_i_q <= 16'h0000;
			prev_q_q <= 16'h0000;
			out_valid <= 1'b0;
			out_i <= 16'h0000;
			out_q <= 16'h0000;
		end else begin
			out_valid <= 1'b0;
			if (!enable) begin
				// Bypass: every sample passes
				phase_q <= 1'b0;
				out_valid <= in_valid;
				if (in_valid) begin
					out_i <= in_i;
					out_q <= in_q;
				end
			end else if (in_valid) begin
				phase_q <= ~phase_q;
				prev_i_q <= in_i;
				prev_q_q <= in_q;
				if (phase_q) begin
					out_valid <= 1'b1;
					out_i <= sum_i[16:1];
					out_q <= sum_q[16:1];
				end
			end
		end
	end
endmodule // half_rate_stage

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the config register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	reg ref_clk = 0, rst_b = 0, reg_write = 0, reg_read = 0, req_valid = 0, sample_valid = 0;
	reg [11:0] reg_addr = 0;
	reg [7:0] reg_wdata = 0;
	reg [47:0] accum_phase = 0;
	reg [15:0] sample_i = 0, sample_q = 0, pattern_i = 0, pattern_q = 0, req_i = 0, req_q = 0;
	wire [7:0] reg_rdata;
	wire [47:0] mix_phase;
	wire lane_valid, req_out_valid;
	wire [15:0] lane_i, lane_q, req_out_i, req_out_q;
	wire [2:0] bandwidth_mode;
	wire [5:0] tuning_word;
	integer bad_count = 0, total_checks = 0, k;
	reg [11:0] ad [0:9] = '{12'h033D, 12'h033E, 12'h033F, 12'h0340, 12'h0341, 12'h0342,
		12'h0347, 12'h041E, 12'h0420, 12'h0422};
	reg [7:0] mk [0:9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h05, 8'hB1, 8'h8E, 8'h3F};
	downconv_requantizer_config_regs DUT (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .accum_phase, .mix_phase, .sample_valid, .sample_i, .sample_q, .pattern_i, .pattern_q,
		.lane_valid, .lane_i, .lane_q, .req_valid, .req_i, .req_q, .req_out_valid, .req_out_i,
		.req_out_q, .bandwidth_mode, .tuning_word);
	initial forever #2.5 ref_clk = ~ref_clk;
	task end_sim;
		begin
			if (bad_count == 0 && total_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		begin
			@(posedge ref_clk);
			reg_write <= 1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge ref_clk);
			reg_write <= 0;
		end
	endtask
	task rd(input [11:0] a, input [7:0] e);
		begin
			@(posedge ref_clk);
			reg_read <= 1;
			reg_addr <= a;
			@(posedge ref_clk);
			reg_read <= 0;
			#1 chk(reg_rdata, e);
		end
	endtask
	task hs(input [15:0] d, input [16:0] e);
		reg [15:0] nq;
		begin
			nq = 16'h0000 - e[15:0];
			@(posedge ref_clk);
			req_valid <= 1;
			req_i <= d;
			req_q <= 16'h0000 - d;
			@(posedge ref_clk);
			req_valid <= 0;
			#1 chk(req_out_valid, e[16]);
			if (e[16]) begin
				chk(req_out_i, e[15:0]);
				chk(req_out_q, nq);
			end
		end
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1;
		for (k = 0; k < 10; k = k + 1)
			rd(ad[k], 8'h00);
		for (k = 0; k < 10; k = k + 1)
			wr(ad[k], 8'hFF);
		wr(12'h0343, 8'hFF);
		for (k = 0; k < 10; k = k + 1)
			rd(ad[k], mk[k]);
		rd(12'h0343, 8'h00);
		chk(tuning_word, 6'h3F);
		chk(bandwidth_mode, 3'h7);
		for (k = 0; k < 6; k = k + 1)
			wr(ad[k], 8'h11 * (k + 1));
		accum_phase <= 48'hFFFF_0000_0000;
		pattern_i <= 16'hAAAA;
		pattern_q <= 16'hBBBB;
		sample_i <= 16'h1111;
		sample_q <= 16'h2222;
		repeat (2) @(posedge ref_clk);
		#1 chk(mix_phase, 48'h6654_4433_2211);
		for (k = 0; k < 4; k = k + 1) begin
			wr(12'h0347, {k[1], 1'b0, k[0]});
			sample_valid <= k[0];
			@(posedge ref_clk);
			#1 chk(lane_i, k[0] ? 16'hAAAA : 16'h1111);
			chk(lane_q, k[1] ? 16'hBBBB : 16'h2222);
			chk(lane_valid, k[0]);
		end
		wr(12'h041E, 8'h00);
		hs(16'h0100, 17'h1_0100);
		wr(12'h041E, 8'h01);
		hs(16'h0100, 17'h0_0000);
		hs(16'h0300, 17'h1_0200);
		wr(12'h041E, 8'h81);
		hs(16'h0100, 17'h0_0000);
		hs(16'h0300, 17'h1_0100);
		end_sim;
	end
	initial begin
		#20000;
		bad_count = bad_count + 1;
		end_sim;
	end
endmodule // testbench
bind downconv_requantizer_config_regs cfg_regs_checker chk_i (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_write,
	.reg_read, .reg_rdata, .accum_phase, .mix_phase, .sample_i, .pattern_i, .lane_i, .sample_q, .pattern_q,
	.lane_q, .req_valid, .req_i,
	.req_out_valid, .req_out_i, .tuning_word);
`default_nettype wire
